/* File: rtl/dext_map.vh */
// Purpose: Named constants for the divide / extend / test-and-set unit
// Assumes: Included by the unit and its divider
// Notes: Definitions only
`ifndef DEXT_MAP_VH
`define DEXT_MAP_VH
// Operation codes on op_code
`define OP_UDIV_B 3'h0
`define OP_UDIV_W 3'h1
`define OP_SDIV_B 3'h2
`define OP_SDIV_W 3'h3
`define OP_ZEXT_W 3'h4
`define OP_ZEXT_L 3'h5
`define OP_SEXT_W 3'h6
`define OP_SEXT_L 3'h7
// State counts per operation
`define ST_UDIV_B 5'h0C
`define ST_UDIV_W 5'h14
`define ST_SDIV_B 5'h0D
`define ST_SDIV_W 5'h15
`define ST_EXT 5'h01
`define ST_TAS 5'h04
// Count value at which done is raised, so done is seen after exactly the state count
`define CNT_LAST 5'h02
// Field positions
`define BYTE_MSB 7
`define WORD_MSB 15
`define LONG_MSB 31
`define TAS_BIT 7
// Flag vector layout {n,z,v,c}
`define FL_N 3
`define FL_Z 2
`define FL_V 1
`define FL_C 0
`define FLAGS_RST 4'h0
// Divider iterations
`define DIV_STEPS_B 5'h08
`define DIV_STEPS_W 5'h10
`endif

/* File: rtl/div_ext_tas_unit.v */
// Purpose: Divide, zero/sign extend and test-and-set execution datapath
// Assumes: Decoder holds operands stable from start until done
// Notes: Flags held in condition_flags_reg; untouched flags keep their value
// Functional notes
// - Unsigned byte divide, remainder high, 12 states
// - Unsigned word divide, remainder high, 20 states
// - Signed byte divide, quotient low, 13 states
// - Signed word divide, quotient low, 21 states
// - Word zero-extend clears 15:8, N V cleared
// - Long zero-extend clears 31:16, one state
// - Word sign-extend copies bit 7 upward
// - Long sign-extend copies bit 15 upward
// - Test-and-set flags byte, writes bit 7 set
// - Unaffected flags keep previous value
`timescale 1ns/100ps
`include "dext_map.vh"
module div_ext_tas_unit (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Register-operand command from decoder
  input wire start,
  input wire [2:0] op_code,
  input wire [31:0] dest_long_reg,
  input wire [15:0] source_reg,
  // Test-and-set command and memory port
  input wire tas_start,
  output reg mem_rd_reg,
  output reg mem_wr_reg,
  output reg mem_lock_reg,
  input wire [7:0] mem_rdata,
  output reg [7:0] mem_wdata_reg,
  // Results
  output reg [31:0] result_reg,
  output reg result_we_reg,
  output reg [3:0] condition_flags_reg,
  output wire busy,
  output reg done_reg
);
  localparam ST_IDLE = 3'h0;
  localparam ST_DIV = 3'h1;
  localparam ST_FIX = 3'h2;
  localparam ST_TAS_RD = 3'h3;
  localparam ST_TAS_WR = 3'h4;
  localparam ST_WAIT = 3'h5;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [4:0] cnt_reg;
  reg [2:0] op_reg;
  reg q_neg_reg;
  reg r_neg_reg;
  wire word_mode;
  wire signed_op;
  wire [15:0] quot;
  wire [16:0] rem;
  wire div_done;
  wire [31:0] abs_dvd;
  wire [15:0] abs_dvs;
  wire [15:0] q_fix;
  wire [15:0] r_fix;
  wire div_zero;
  wire [15:0] dvs_op;
  wire [31:0] dvs_mag;

  // Magnitude of a value of given width, sign taken from top bit
  function [31:0] magnitude;
    input [31:0] v;
    input wide;
    input sgn;
    reg [31:0] t;
    begin
      t = wide ? v : {16'h0000, v[15:0]};
      if (sgn && (wide ? v[`LONG_MSB] : v[`WORD_MSB])) begin
        t = wide ? (32'h00000000 - v) : {16'h0000, 16'h0000 - v[15:0]};
      end
      magnitude = t;
    end
  endfunction

  // Negate a 16-bit value when asked
  function [15:0] cond_neg;
    input [15:0] v;
    input neg;
    begin
      cond_neg = neg ? (16'h0000 - v) : v;
    end
  endfunction

  assign word_mode = op_code[0];
  assign signed_op = op_code[1];
  assign abs_dvd = magnitude(dest_long_reg, word_mode, signed_op);
  // Byte divisor is widened first so its sign sits where the magnitude function looks
  assign dvs_op = word_mode ? source_reg
                            : (signed_op ? {{8{source_reg[`BYTE_MSB]}}, source_reg[7:0]} : {8'h00, source_reg[7:0]});
  assign dvs_mag = magnitude({16'h0000, dvs_op}, 1'b0, signed_op);
  assign abs_dvs = dvs_mag[15:0];
  assign busy = (state_reg != ST_IDLE);
  assign div_zero = (quot == 16'h0000);
  assign q_fix = cond_neg(quot, q_neg_reg);
  assign r_fix = cond_neg(rem[15:0], r_neg_reg);

  restoring_divider u_div (
    .clk(clk),
    .rst_n(rst_n),
    .start(start && (state_reg == ST_IDLE) && !op_code[2]),
    .word_mode(word_mode),
    .dividend(abs_dvd),
    .divisor(abs_dvs),
    .quotient_reg(quot),
    .remainder_reg(rem),
    .done(div_done)
  );

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start && !op_code[2]) begin
          state_next = ST_DIV;
        end else if (tas_start) begin
          state_next = ST_TAS_RD;
        end
      end
      ST_DIV: begin
        if (div_done) begin
          state_next = ST_FIX;
        end
      end
      ST_FIX: state_next = ST_WAIT;
      ST_TAS_RD: state_next = ST_TAS_WR;
      ST_TAS_WR: state_next = ST_WAIT;
      ST_WAIT: begin
        if (cnt_reg == `CNT_LAST) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 5'h00;
      op_reg <= 3'h0;
      q_neg_reg <= 1'b0;
      r_neg_reg <= 1'b0;
      mem_rd_reg <= 1'b0;
      mem_wr_reg <= 1'b0;
      mem_lock_reg <= 1'b0;
      mem_wdata_reg <= 8'h00;
      result_reg <= 32'h00000000;
      result_we_reg <= 1'b0;
      condition_flags_reg <= `FLAGS_RST;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      result_we_reg <= 1'b0;
      done_reg <= 1'b0;
      mem_rd_reg <= 1'b0;
      mem_wr_reg <= 1'b0;
      if (cnt_reg != 5'h00) begin
        cnt_reg <= cnt_reg - 5'h01;
      end
      // Lock stays up through the cycle in which done is shown
      if (done_reg) begin
        mem_lock_reg <= 1'b0;
      end
      if (state_reg == ST_WAIT && cnt_reg == `CNT_LAST) begin
        done_reg <= 1'b1;
      end
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            op_reg <= op_code;
            case (op_code)
              `OP_UDIV_B: cnt_reg <= `ST_UDIV_B;
              `OP_UDIV_W: cnt_reg <= `ST_UDIV_W;
              `OP_SDIV_B: cnt_reg <= `ST_SDIV_B;
              `OP_SDIV_W: cnt_reg <= `ST_SDIV_W;
              default: cnt_reg <= `ST_EXT;
            endcase
            if (word_mode) begin
              q_neg_reg <= signed_op && (dest_long_reg[`LONG_MSB] ^ source_reg[`WORD_MSB]);
              r_neg_reg <= signed_op && dest_long_reg[`LONG_MSB];
            end else begin
              q_neg_reg <= signed_op && (dest_long_reg[`WORD_MSB] ^ source_reg[`BYTE_MSB]);
              r_neg_reg <= signed_op && dest_long_reg[`WORD_MSB];
            end
            // Extends finish in a single state; N, Z, V updated, C kept
            if (op_code[2]) begin
              result_we_reg <= 1'b1;
              done_reg <= 1'b1;
              cnt_reg <= 5'h00;
              case (op_code)
                `OP_ZEXT_W: begin
                  result_reg <= {dest_long_reg[31:16], 8'h00, dest_long_reg[7:0]};
                  condition_flags_reg[`FL_N] <= 1'b0;
                  condition_flags_reg[`FL_Z] <= (dest_long_reg[7:0] == 8'h00);
                end
                `OP_ZEXT_L: begin
                  result_reg <= {16'h0000, dest_long_reg[15:0]};
                  condition_flags_reg[`FL_N] <= 1'b0;
                  condition_flags_reg[`FL_Z] <= (dest_long_reg[15:0] == 16'h0000);
                end
                `OP_SEXT_W: begin
                  result_reg <= {dest_long_reg[31:16], {8{dest_long_reg[`BYTE_MSB]}},
                                 dest_long_reg[7:0]};
                  condition_flags_reg[`FL_N] <= dest_long_reg[`BYTE_MSB];
                  condition_flags_reg[`FL_Z] <= (dest_long_reg[7:0] == 8'h00);
                end
                default: begin
                  result_reg <= {{16{dest_long_reg[`WORD_MSB]}}, dest_long_reg[15:0]};
                  condition_flags_reg[`FL_N] <= dest_long_reg[`WORD_MSB];
                  condition_flags_reg[`FL_Z] <= (dest_long_reg[15:0] == 16'h0000);
                end
              endcase
              condition_flags_reg[`FL_V] <= 1'b0;
            end
          end else if (tas_start) begin
            cnt_reg <= `ST_TAS;
            mem_rd_reg <= 1'b1;
            mem_lock_reg <= 1'b1;
          end
        end
        ST_TAS_WR: begin
          // Read data is due one cycle after the read strobe
          mem_wr_reg <= 1'b1;
          mem_wdata_reg <= mem_rdata | (8'h01 << `TAS_BIT);
          condition_flags_reg[`FL_N] <= mem_rdata[`BYTE_MSB];
          condition_flags_reg[`FL_Z] <= (mem_rdata == 8'h00);
          condition_flags_reg[`FL_V] <= 1'b0;
        end
        ST_FIX: begin
          result_we_reg <= 1'b1;
          if (op_reg[0]) begin
            result_reg <= {r_fix, q_fix};
            condition_flags_reg[`FL_N] <= q_fix[`WORD_MSB];
          end else begin
            result_reg <= {dest_long_reg[31:16], r_fix[7:0], q_fix[7:0]};
            condition_flags_reg[`FL_N] <= q_fix[`BYTE_MSB];
          end
          condition_flags_reg[`FL_Z] <= (abs_dvs == 16'h0000) || div_zero;
          // C is written only by reset, V not here: both keep their value
        end
        default: begin
        end
      endcase
    end
  end
endmodule // div_ext_tas_unit

/* File: rtl/restoring_divider.v */
// Purpose: Iterative unsigned restoring divider, one quotient bit per clock
// Assumes: Operands held stable during a run; upper half of dividend below divisor
// Notes: Byte mode uses all 16 bits of divisor and a 16-bit dividend
`timescale 1ns/100ps
`include "dext_map.vh"
module restoring_divider (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Command
  input wire start,
  input wire word_mode,
  input wire [31:0] dividend,
  input wire [15:0] divisor,
  // Result
  output reg [15:0] quotient_reg,
  output reg [16:0] remainder_reg,
  output wire done
);
  reg [4:0] count_reg;
  reg busy_reg;
  reg [31:0] dvd_reg;
  wire [16:0] trial;
  wire [16:0] rem_shift;
  wire [31:0] dvd_shift;
  wire dvd_top;
  // Upper half preloads the remainder, lower half is shifted in bit by bit
  assign dvd_top = word_mode ? dvd_reg[`WORD_MSB] : dvd_reg[`BYTE_MSB];
  assign rem_shift = {remainder_reg[15:0], dvd_top};
  assign trial = rem_shift - {1'b0, divisor};
  assign dvd_shift = {dvd_reg[30:0], 1'b0};
  assign done = busy_reg && (count_reg == 5'h01);
  always @(posedge clk) begin
    if (!rst_n) begin
      count_reg <= 5'h00;
      busy_reg <= 1'b0;
      dvd_reg <= 32'h00000000;
      quotient_reg <= 16'h0000;
      remainder_reg <= 17'h00000;
    end else if (start) begin
      busy_reg <= 1'b1;
      count_reg <= word_mode ? `DIV_STEPS_W : `DIV_STEPS_B;
      dvd_reg <= dividend;
      quotient_reg <= 16'h0000;
      remainder_reg <= word_mode ? {1'b0, dividend[31:16]} : {9'h000, dividend[15:8]};
    end else if (busy_reg) begin
      dvd_reg <= dvd_shift;
      count_reg <= count_reg - 5'h01;
      if (count_reg == 5'h01) begin
        busy_reg <= 1'b0;
      end
      if (!trial[16]) begin
        remainder_reg <= trial;
        quotient_reg <= {quotient_reg[14:0], 1'b1};
      end else begin
        remainder_reg <= rem_shift;
        quotient_reg <= {quotient_reg[14:0], 1'b0};
      end
    end
  end
endmodule // restoring_divider

/* File: sim/byte_mem_model.sv */
// Purpose: One-byte memory answering the unit's read and write strobes
// Assumes: Read data is due the cycle after the read strobe
// Notes: Outside that cycle the read bus toggles so stale data cannot pass
`timescale 1ns/100ps
module byte_mem_model (
  // Clock
  input wire clk,
  // Preload from bench
  input wire load,
  input wire [7:0] load_data,
  // Memory port
  input wire mem_rd_reg,
  input wire mem_wr_reg,
  input wire [7:0] mem_wdata_reg,
  output reg [7:0] mem_rdata,
  output reg [7:0] cell_reg
);
  initial mem_rdata = 8'h5A;
  always @(posedge clk) begin
    if (load)
      cell_reg <= load_data;
    else if (mem_wr_reg)
      cell_reg <= mem_wdata_reg;
    if (mem_rd_reg)
      mem_rdata <= cell_reg;
    else
      mem_rdata <= ~mem_rdata;
  end
endmodule // byte_mem_model

/* File: sim/div_ext_tas_asserts.sv */
// Purpose: Port-level timing and result checks of the unit
// Assumes: One clock, synchronous active-low reset
// Notes: Bound onto every instance of the unit
`timescale 1ns/100ps
`include "dext_map.vh"
module div_ext_tas_asserts (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Commands
  input wire start,
  input wire tas_start,
  input wire [2:0] op_code,
  input wire [31:0] dest_long_reg,
  // Memory port
  input wire mem_rd_reg,
  input wire mem_wr_reg,
  input wire mem_lock_reg,
  input wire [7:0] mem_wdata_reg,
  // Results
  input wire [31:0] result_reg,
  input wire result_we_reg,
  input wire [3:0] condition_flags_reg,
  input wire busy,
  input wire done_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire go = start && !busy;
  a_udivb_states: assert property (go && op_code == `OP_UDIV_B |-> ##12 done_reg)
    else $error("udiv.b length");
  a_udivw_states: assert property (go && op_code == `OP_UDIV_W |-> ##20 done_reg)
    else $error("udiv.w length");
  a_sdivb_states: assert property (go && op_code == `OP_SDIV_B |-> ##13 done_reg)
    else $error("sdiv.b length");
  a_sdivw_states: assert property (go && op_code == `OP_SDIV_W |-> ##21 done_reg)
    else $error("sdiv.w length");
  a_zext_word: assert property (go && op_code == `OP_ZEXT_W |=> condition_flags_reg[`FL_N] == 1'b0
    && condition_flags_reg[`FL_V] == 1'b0 && result_reg[15:0] == {8'h00, $past(dest_long_reg[7:0])})
    else $error("zext.w result");
  a_zext_long: assert property (go && op_code == `OP_ZEXT_L |=> done_reg && result_we_reg
    && result_reg[31:16] == 16'h0000) else $error("zext.l result");
  a_sext_word: assert property (go && op_code == `OP_SEXT_W |=>
    result_reg[15:8] == {8{$past(dest_long_reg[7])}} && condition_flags_reg[`FL_N] == $past(dest_long_reg[7]))
    else $error("sext.w result");
  a_sext_long: assert property (go && op_code == `OP_SEXT_L |=>
    result_reg == {{16{$past(dest_long_reg[15])}}, $past(dest_long_reg[15:0])} && condition_flags_reg[`FL_V] == 1'b0)
    else $error("sext.l result");
  a_tas_states: assert property (tas_start && !start && !busy |-> ##4 done_reg)
    else $error("tas length");
  a_tas_write: assert property (mem_wr_reg |-> mem_wdata_reg[`TAS_BIT] && mem_lock_reg)
    else $error("tas write");
  a_lock_held: assert property (mem_rd_reg |-> mem_lock_reg[*4]) else $error("tas lock dropped");
  a_carry_kept: assert property ($stable(condition_flags_reg[`FL_C])) else $error("carry changed");
  cover property (go && op_code == `OP_SDIV_W);
  cover property (mem_wr_reg);
  cover property (start && busy);
endmodule // div_ext_tas_asserts
bind div_ext_tas_unit div_ext_tas_asserts chk_u (.clk(clk), .rst_n(rst_n), .start(start), .tas_start(tas_start),
  .op_code(op_code), .dest_long_reg(dest_long_reg), .mem_rd_reg(mem_rd_reg), .mem_wr_reg(mem_wr_reg),
  .mem_lock_reg(mem_lock_reg), .mem_wdata_reg(mem_wdata_reg), .result_reg(result_reg),
  .result_we_reg(result_we_reg), .condition_flags_reg(condition_flags_reg), .busy(busy), .done_reg(done_reg));

/* File: sim/div_ext_tas_unit_test.sv */
// Purpose: Directed bench for divide, extend and test-and-set
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Expected results are worked out by hand
`timescale 1ns/100ps
`include "dext_map.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %s exp %0h got %0h", n, e, g); end end
module div_ext_tas_unit_test;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg start = 1'b0;
  reg tas_start = 1'b0;
  reg load = 1'b0;
  reg [2:0] op_code = 3'h0;
  reg [31:0] dest_long_reg = 32'h0;
  reg [15:0] source_reg = 16'h0;
  reg [7:0] load_data = 8'h0;
  wire mem_rd_reg, mem_wr_reg, mem_lock_reg, result_we_reg, busy, done_reg;
  wire [7:0] mem_rdata, mem_wdata_reg, cell_reg;
  wire [31:0] result_reg;
  wire [3:0] condition_flags_reg;
  int failures = 0;
  int compares = 0;
  int n;
  always #25 clk = ~clk;
  div_ext_tas_unit dut_u (.clk(clk), .rst_n(rst_n), .start(start), .op_code(op_code), .dest_long_reg(dest_long_reg),
    .source_reg(source_reg), .tas_start(tas_start), .mem_rd_reg(mem_rd_reg), .mem_wr_reg(mem_wr_reg),
    .mem_lock_reg(mem_lock_reg), .mem_rdata(mem_rdata), .mem_wdata_reg(mem_wdata_reg), .result_reg(result_reg),
    .result_we_reg(result_we_reg), .condition_flags_reg(condition_flags_reg), .busy(busy), .done_reg(done_reg));
  byte_mem_model mem_u (.clk(clk), .load(load), .load_data(load_data), .mem_rd_reg(mem_rd_reg),
    .mem_wr_reg(mem_wr_reg), .mem_wdata_reg(mem_wdata_reg), .mem_rdata(mem_rdata), .cell_reg(cell_reg));
  task print_verdict;
    if (failures == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Issue one request, optionally repeat start while busy; n counts edges from taking edge to done
  task go(input t, input [2:0] op, input [31:0] d, input [15:0] s, input poke);
    @(posedge clk);
    #1 load = 1'b0;
    op_code = op;
    dest_long_reg = d;
    source_reg = s;
    start = !t;
    tas_start = t;
    @(posedge clk);
    #1 start = poke;
    tas_start = 1'b0;
    n = 1;
    while (done_reg !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1 start = 1'b0;
      n++;
    end
    if (n == 40) begin
      failures++;
      print_verdict;
    end
  endtask
  task run(input [2:0] op, input [31:0] d, input [15:0] s, input [31:0] er, input [4:0] es, input [3:0] ef);
    go(1'b0, op, d, s, !op[2]);
    `CHK("result", er, result_reg)
    `CHK("states", es, n[4:0])
    `CHK("flags", ef, condition_flags_reg)
  endtask
  task t_tas(input [7:0] b, input [3:0] ef);
    @(posedge clk);
    #1 load = 1'b1;
    load_data = b;
    go(1'b1, 3'h0, 32'h0, 16'h0, 1'b0);
    `CHK("tas states", 5'h04, n[4:0])
    `CHK("tas flags", ef, condition_flags_reg)
    `CHK("tas byte", b | 8'h80, cell_reg)
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    run(`OP_UDIV_B, 32'hCAFE1234, 16'hAB56, 32'hCAFE1036, 5'h0C, 4'h0);
    run(`OP_UDIV_W, 32'h00123456, 16'h0789, 32'h039C026A, 5'h14, 4'h0);
    run(`OP_SDIV_B, 32'h0000FF9C, 16'hFF07, 32'h0000FEF2, 5'h0D, 4'h8);
    run(`OP_SDIV_W, 32'hFFFE7960, 16'h012C, 32'hFF9CFEB3, 5'h15, 4'h8);
    run(`OP_ZEXT_W, 32'h0000A580, 16'h0, 32'h00000080, 5'h01, 4'h0);
    run(`OP_ZEXT_W, 32'h00001200, 16'h0, 32'h00000000, 5'h01, 4'h4);
    run(`OP_ZEXT_L, 32'hBEEF8080, 16'h0, 32'h00008080, 5'h01, 4'h0);
    run(`OP_SEXT_W, 32'h00001280, 16'h0, 32'h0000FF80, 5'h01, 4'h8);
    run(`OP_SEXT_L, 32'h12348080, 16'h0, 32'hFFFF8080, 5'h01, 4'h8);
    run(`OP_SEXT_L, 32'hFFFF7F00, 16'h0, 32'h00007F00, 5'h01, 4'h0);
    t_tas(8'h00, 4'h4);
    t_tas(8'hC3, 4'h8);
    print_verdict;
  end
endmodule // div_ext_tas_unit_test
